// [common/acr_pkg.sv]
// Package with register map, field positions and constants for the audio control block
`default_nettype none
package acr_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] ACR_IDX_MODE = 8'h06;
   localparam logic [7:0] ACR_IDX_COEF = 8'h07;
   localparam logic [7:0] ACR_IDX_IRQ_STAT = 8'h20;
   localparam logic [7:0] ACR_IDX_IRQ_MASK = 8'h21;
   localparam logic [7:0] ACR_IDX_EXT = 8'h22;
   // Field positions of the mode register
   localparam int ACR_B_LINK_HI = 15;
   localparam int ACR_B_LINK_LO = 14;
   localparam int ACR_B_RATE = 13;
   localparam int ACR_B_XFER = 12;
   localparam int ACR_B_ROLE = 11;
   localparam int ACR_B_ADC_OVF = 8;
   localparam int ACR_B_DACL_OVF = 7;
   localparam int ACR_B_DACR_OVF = 6;
   localparam int ACR_B_RSV_HI = 5;
   localparam int ACR_B_RSV_LO = 4;
   localparam int ACR_B_CLIP = 3;
   localparam int ACR_B_REV_HI = 2;
   // Link field encodings
   localparam logic [1:0] ACR_LINK_R2L = 2'h1;
   localparam logic [1:0] ACR_LINK_L2R = 2'h2;
   // Reset values
   localparam logic [15:0] ACR_COEF_RST = 16'h6BE3;
   localparam logic [1:0] ACR_LINK_RST = 2'h0;
   // Revision code, value arbitrary
   localparam logic [2:0] ACR_REV_CODE = 3'h1;
   // Per-rate derived settings: divider for the measurement converter clock
   localparam logic [7:0] ACR_DIV_48K = 8'h20;
   localparam logic [7:0] ACR_DIV_44K = 8'h1D;
   localparam int ACR_NFLAG = 3;
   localparam logic [1:0] ACR_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ACR_HTRANS_SEQ = 2'h3;
endpackage
`default_nettype wire

// [logic/acr_regs.sv]
// Audio mode/flag register bank with AHB-Lite slave and interrupt
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Link field 00 or 11 keeps left and right volumes independent.
// - Link field 01 drives left volume from the right setting.
// - Link field 10 drives right volume from the left setting.
// - Bit 13 picks reference rate, 0 is 48 kHz, 1 is 44.1 kHz.
// - Rate choice sets de-emphasis set, AGC time constants, converter divider.
// - Bit 12 picks continuous or 256-s transfer mode, reset 0.
// - Bit 11 picks slave or master role, reset 0.
// - Bit 8 flags ADC overflow, cleared by reading the register.
// - Bit 7 flags left DAC overflow, cleared by reading.
// - Bit 6 flags right DAC overflow, cleared by reading.
// - Bit 3 enables microphone AGC clip stepping, reset 0.
// - Clip stepping acts only while AGC is selected for an input.
// - Bits 2 to 0 read a fixed revision code, writes ignored.
// - Next register holds left bass coefficient zero, reset 27619.
// - Bass coefficients are used only while effects filter is enabled.
module acr_regs
   import acr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic adc_ovf_in,
   input wire logic dacl_ovf_in,
   input wire logic dacr_ovf_in,
   input wire logic agc_active_in,
   input wire logic effects_filter_enable,
   input wire logic [15:0] left_vol_in,
   input wire logic [15:0] right_vol_in,
   output logic [15:0] left_vol_out,
   output logic [15:0] right_vol_out,
   output logic rate_44k1,
   output logic [7:0] meas_div,
   output logic deemph_set_44k1,
   output logic agc_tc_44k1,
   output logic transfer_mode_select,
   output logic role_select,
   output logic agc_clip_step_active,
   output logic [15:0] bass_coef_active,
   output logic irq
);

   // ****************************************************************
   // Bus address phase capture
   // ****************************************************************
   logic wr_pend_reg;
   logic [7:0] wr_idx_reg;
   logic [31:0] rdata_next;
   logic [7:0] a_idx;
   logic rd_go;
   logic wr_go;
   assign a_idx = haddr[9:2];
   assign rd_go = hsel && hready && htrans[1] && !hwrite;
   assign wr_go = hsel && hready && htrans[1] && hwrite;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 8'h00;
      end
      else
      begin
         wr_pend_reg <= wr_go;
         if (wr_go)
         begin
            wr_idx_reg <= a_idx;
         end
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // Overflow and AGC input synchronisers
   // ****************************************************************
   logic [ACR_NFLAG-1:0] ovf_raw;
   logic [ACR_NFLAG-1:0] ovf_s1_reg;
   logic [ACR_NFLAG-1:0] ovf_s2_reg;
   logic agc_s1_reg;
   logic agc_s2_reg;
   assign ovf_raw = {adc_ovf_in, dacl_ovf_in, dacr_ovf_in};

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ovf_s1_reg <= '0;
         ovf_s2_reg <= '0;
         agc_s1_reg <= 1'b0;
         agc_s2_reg <= 1'b0;
      end
      else
      begin
         ovf_s1_reg <= ovf_raw;
         ovf_s2_reg <= ovf_s1_reg;
         agc_s1_reg <= agc_active_in;
         agc_s2_reg <= agc_s1_reg;
      end
   end

   // ****************************************************************
   // Control fields
   // ****************************************************************
   logic [1:0] link_reg;
   logic rate_reg;
   logic xfer_reg;
   logic role_reg;
   logic [1:0] rsv_reg;
   logic clip_reg;
   logic [15:0] coef_reg;
   logic [ACR_NFLAG-1:0] mask_reg;
   logic wr_mode;
   logic wr_coef;
   logic wr_mask;
   logic wr_stat;
   assign wr_mode = wr_pend_reg && (wr_idx_reg == ACR_IDX_MODE);
   assign wr_coef = wr_pend_reg && (wr_idx_reg == ACR_IDX_COEF);
   assign wr_mask = wr_pend_reg && (wr_idx_reg == ACR_IDX_IRQ_MASK);
   assign wr_stat = wr_pend_reg && (wr_idx_reg == ACR_IDX_IRQ_STAT);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         link_reg <= ACR_LINK_RST;
         rate_reg <= 1'b0;
         xfer_reg <= 1'b0;
         role_reg <= 1'b0;
         rsv_reg <= 2'h0;
         clip_reg <= 1'b0;
      end
      else if (wr_mode)
      begin
         link_reg <= hwdata[ACR_B_LINK_HI:ACR_B_LINK_LO];
         rate_reg <= hwdata[ACR_B_RATE];
         xfer_reg <= hwdata[ACR_B_XFER];
         role_reg <= hwdata[ACR_B_ROLE];
         rsv_reg <= hwdata[ACR_B_RSV_HI:ACR_B_RSV_LO];
         clip_reg <= hwdata[ACR_B_CLIP];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         coef_reg <= ACR_COEF_RST;
      end
      else if (wr_coef)
      begin
         coef_reg <= hwdata[15:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mask_reg <= '0;
      end
      else if (wr_mask)
      begin
         mask_reg <= hwdata[ACR_NFLAG-1:0];
      end
   end

   // ****************************************************************
   // Sticky flags: read-clear and interrupt status
   // ****************************************************************
   logic [ACR_NFLAG-1:0] flag_reg;
   logic [ACR_NFLAG-1:0] stat_reg;
   logic rd_mode;
   assign rd_mode = rd_go && (a_idx == ACR_IDX_MODE);

   genvar gi;
   generate
      for (gi = 0; gi < ACR_NFLAG; gi++)
      begin : g_flag
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               flag_reg[gi] <= 1'b0;
            end
            else if (ovf_s2_reg[gi])
            begin
               flag_reg[gi] <= 1'b1;
            end
            else if (rd_mode)
            begin
               flag_reg[gi] <= 1'b0;
            end
         end
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               stat_reg[gi] <= 1'b0;
            end
            else if (ovf_s2_reg[gi])
            begin
               stat_reg[gi] <= 1'b1;
            end
            else if (wr_stat && hwdata[gi])
            begin
               stat_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(stat_reg & mask_reg);
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (a_idx)
         ACR_IDX_MODE:
         begin
            rdata_next[ACR_B_LINK_HI:ACR_B_LINK_LO] = link_reg;
            rdata_next[ACR_B_RATE] = rate_reg;
            rdata_next[ACR_B_XFER] = xfer_reg;
            rdata_next[ACR_B_ROLE] = role_reg;
            rdata_next[ACR_B_ADC_OVF] = flag_reg[2];
            rdata_next[ACR_B_DACL_OVF] = flag_reg[1];
            rdata_next[ACR_B_DACR_OVF] = flag_reg[0];
            rdata_next[ACR_B_RSV_HI:ACR_B_RSV_LO] = rsv_reg;
            rdata_next[ACR_B_CLIP] = clip_reg;
            rdata_next[ACR_B_REV_HI:0] = ACR_REV_CODE;
         end
         ACR_IDX_COEF: rdata_next[15:0] = coef_reg;
         ACR_IDX_IRQ_STAT: rdata_next[ACR_NFLAG-1:0] = stat_reg;
         ACR_IDX_IRQ_MASK: rdata_next[ACR_NFLAG-1:0] = mask_reg;
         ACR_IDX_EXT: rdata_next[ACR_NFLAG-1:0] = ovf_s2_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (rd_go)
      begin
         hrdata <= rdata_next;
      end
   end

   // ****************************************************************
   // Derived outputs
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         left_vol_out <= 16'h0000;
         right_vol_out <= 16'h0000;
      end
      else
      begin
         case (link_reg)
            ACR_LINK_R2L:
            begin
               left_vol_out <= right_vol_in;
               right_vol_out <= right_vol_in;
            end
            ACR_LINK_L2R:
            begin
               left_vol_out <= left_vol_in;
               right_vol_out <= left_vol_in;
            end
            default:
            begin
               left_vol_out <= left_vol_in;
               right_vol_out <= right_vol_in;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rate_44k1 <= 1'b0;
         deemph_set_44k1 <= 1'b0;
         agc_tc_44k1 <= 1'b0;
         meas_div <= ACR_DIV_48K;
         transfer_mode_select <= 1'b0;
         role_select <= 1'b0;
         agc_clip_step_active <= 1'b0;
         bass_coef_active <= 16'h0000;
      end
      else
      begin
         rate_44k1 <= rate_reg;
         deemph_set_44k1 <= rate_reg;
         agc_tc_44k1 <= rate_reg;
         meas_div <= rate_reg ? ACR_DIV_44K : ACR_DIV_48K;
         transfer_mode_select <= xfer_reg;
         role_select <= role_reg;
         agc_clip_step_active <= clip_reg && agc_s2_reg;
         // coefficient used only with effects on
         bass_coef_active <= effects_filter_enable ? coef_reg : 16'h0000;
      end
   end

endmodule
`default_nettype wire

// [test/acr_regs_sva.sv]
// Concurrent checks for the audio control register bank
`timescale 1ns/1ps
`default_nettype none
module acr_chk
   import acr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic agc_active_in,
   input wire logic effects_filter_enable,
   input wire logic [15:0] left_vol_in,
   input wire logic [15:0] right_vol_in,
   input wire logic [15:0] left_vol_out,
   input wire logic [15:0] right_vol_out,
   input wire logic rate_44k1,
   input wire logic [7:0] meas_div,
   input wire logic transfer_mode_select,
   input wire logic role_select,
   input wire logic agc_clip_step_active,
   input wire logic [15:0] bass_coef_active
);
   // ****
   // Shadow of the writable fields
   // ****
   logic ap_q, aw_q, wr_dp, rd_mode;
   logic [7:0] ai_q;
   logic [15:0] sh, csh;
   logic [1:0] age;
   assign wr_dp = ap_q && aw_q && hready;
   assign rd_mode = ap_q && !aw_q && hready && ai_q == ACR_IDX_MODE;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         ap_q <= 1'b0;
         aw_q <= 1'b0;
         ai_q <= 8'h00;
      end
      else if (hready)
      begin
         ap_q <= hsel && htrans[1];
         aw_q <= hwrite;
         ai_q <= haddr[9:2];
      end
   // Age counts edges since the last write, so outputs have settled at 3
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         sh <= 16'h0000;
         csh <= 16'h6BE3;
         age <= 2'h0;
      end
      else
      begin
         age <= wr_dp ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
         if (wr_dp && ai_q == ACR_IDX_MODE)
            sh <= hwdata[15:0] & 16'hF838;
         if (wr_dp && ai_q == ACR_IDX_COEF)
            csh <= hwdata[15:0];
      end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   rate_out_a: assert property (age == 2'h3 |-> rate_44k1 == sh[13])
      else $error("rate select wrong");
   meas_div_a: assert property (age == 2'h3
      |-> meas_div == (sh[13] ? ACR_DIV_44K : ACR_DIV_48K)) else $error("divider wrong");
   xfer_role_a: assert property (age == 2'h3
      |-> transfer_mode_select == sh[12] && role_select == sh[11]) else $error("mode wrong");
   link_left_a: assert property (age == 2'h3 && $stable(left_vol_in) && $stable(right_vol_in)
      |-> left_vol_out == (sh[15:14] == ACR_LINK_R2L ? right_vol_in : left_vol_in))
      else $error("left volume wrong");
   link_right_a: assert property (age == 2'h3 && $stable(left_vol_in) && $stable(right_vol_in)
      |-> right_vol_out == (sh[15:14] == ACR_LINK_L2R ? left_vol_in : right_vol_in))
      else $error("right volume wrong");
   clip_gate_a: assert property (age == 2'h3 && !sh[3] |-> !agc_clip_step_active)
      else $error("clip step active while off");
   clip_idle_a: assert property (!agc_active_in [*4] |=> !agc_clip_step_active)
      else $error("clip step active without agc");
   coef_gate_a: assert property (!effects_filter_enable |=> bass_coef_active == 16'h0000)
      else $error("coefficient used while disabled");
   coef_pass_a: assert property (effects_filter_enable ##1 age == 2'h3
      |-> bass_coef_active == csh) else $error("coefficient wrong");
   mode_read_a: assert property (rd_mode && age == 2'h3
      |-> {hrdata[31:9], hrdata[5:0]} == {16'h0, sh[15:11], 2'h0, sh[5:3], ACR_REV_CODE})
      else $error("mode read wrong");
endmodule
bind acr_regs acr_chk u_chk (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .agc_active_in, .effects_filter_enable, .left_vol_in, .right_vol_in,
   .left_vol_out, .right_vol_out, .rate_44k1, .meas_div, .transfer_mode_select,
   .role_select, .agc_clip_step_active, .bass_coef_active);
`default_nettype wire

// [test/tb_audio_control3_regs.sv]
// Self-checking bench for the audio control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_audio_control3_regs
   import acr_pkg::*;
;
   logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, efe = 1'b0, agc = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] ovf = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [15:0] lv = 16'h1234, rv = 16'hABCD, lvo, rvo, bca;
   logic [7:0] md;
   logic [4:0] cfg;
   logic rdy, clp, irq, rsp;
   int fails = 0, checked = 0;
   acr_regs dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(rdy), .hrdata, .hreadyout(rdy), .hresp(rsp), .adc_ovf_in(ovf[2]),
      .dacl_ovf_in(ovf[1]), .dacr_ovf_in(ovf[0]), .agc_active_in(agc),
      .effects_filter_enable(efe), .left_vol_in(lv), .right_vol_in(rv), .left_vol_out(lvo),
      .right_vol_out(rvo), .rate_44k1(cfg[4]), .meas_div(md), .deemph_set_44k1(cfg[3]),
      .agc_tc_44k1(cfg[2]), .transfer_mode_select(cfg[1]), .role_select(cfg[0]),
      .agc_clip_step_active(clp), .bass_coef_active(bca), .irq);
   always #5 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One AHB single transfer, address phase then data phase
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= ACR_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      r = hrdata;
      chk("hresp", 32'(rsp), 32'h0);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, idx, d, x);
   endtask
   task automatic rdc(input string n, input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, idx, 32'h0, x);
      chk(n, x, e);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset;
      rdc("mode", ACR_IDX_MODE, {29'h0, ACR_REV_CODE});
      rdc("coef", ACR_IDX_COEF, 32'h00006BE3);
      chk("div", 32'(md), 32'(ACR_DIV_48K));
   endtask
   // Every link code, with rate, mode, role and spare bits toggled alongside
   // bench rates legal
   task automatic t_link;
      logic [15:0] el, er;
      for (int k = 0; k < 4; k++)
      begin
         wr(ACR_IDX_MODE, {16'h0, k[1:0], {3{k[0]}}, 5'h1F, {3{k[0]}}, 3'h7});
         tk(3);
         el = (k == 1) ? rv : lv;
         er = (k == 2) ? lv : rv;
         chk("vol", {lvo, rvo}, {el, er});
         chk("cfg", 32'(cfg), 32'({5{k[0]}}));
         chk("div", 32'(md), 32'(k[0] ? ACR_DIV_44K : ACR_DIV_48K));
         rdc("mode", ACR_IDX_MODE, {16'h0, k[1:0], {3{k[0]}}, 5'h0, {3{k[0]}}, ACR_REV_CODE});
      end
   endtask
   task automatic t_clip;
      agc <= 1'b1;
      tk(5);
      chk("clip", 32'(clp), 32'h1);
      agc <= 1'b0;
      tk(5);
      chk("clip", 32'(clp), 32'h0);
      agc <= 1'b1;
      wr(ACR_IDX_MODE, 32'h0);
      tk(5);
      chk("clip", 32'(clp), 32'h0);
      agc <= 1'b0;
   endtask
   task automatic t_coef;
      wr(ACR_IDX_COEF, 32'hFFFF5A5A);
      tk(3);
      rdc("coef", ACR_IDX_COEF, 32'h00005A5A);
      chk("bass", 32'(bca), 32'h0);
      efe <= 1'b1;
      tk(3);
      chk("bass", 32'(bca), 32'h00005A5A);
      efe <= 1'b0;
      wr(8'h30, 32'hFFFFFFFF);
      rdc("unmapped", 8'h30, 32'h0);
   endtask
   // Each overflow: flag sticks, clears on read, raises the masked interrupt
   task automatic t_ovf;
      for (int i = 0; i < 3; i++)
      begin
         wr(ACR_IDX_IRQ_MASK, 32'h0);
         ovf <= 3'h4 >> i;
         tk(1);
         ovf <= 3'h0;
         tk(5);
         chk("irq", 32'(irq), 32'h0);
         rdc("stat", ACR_IDX_IRQ_STAT, 32'(3'h4 >> i));
         rdc("flag", ACR_IDX_MODE, {23'h0, 3'h4 >> i, 3'h0, ACR_REV_CODE});
         rdc("flag", ACR_IDX_MODE, {29'h0, ACR_REV_CODE});
         wr(ACR_IDX_IRQ_MASK, 32'h7);
         tk(2);
         chk("irq", 32'(irq), 32'h1);
         wr(ACR_IDX_IRQ_STAT, 32'(3'h4 >> i));
         tk(2);
         chk("irq", 32'(irq), 32'h0);
      end
      // Held overflow: raw view shows it and a read cannot clear it
      ovf <= 3'h7;
      tk(3);
      rdc("ext", ACR_IDX_EXT, 32'h00000007);
      rdc("held", ACR_IDX_MODE, {23'h0, 3'h7, 3'h0, ACR_REV_CODE});
      rdc("held", ACR_IDX_MODE, {23'h0, 3'h7, 3'h0, ACR_REV_CODE});
      ovf <= 3'h0;
   endtask
   task automatic results;
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100us;
      fails++;
      results;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_link;
      t_clip;
      t_coef;
      t_ovf;
      results;
   end
endmodule
`default_nettype wire
